/* File: common/viu_pkg.sv */
// Constants, types and helpers shared by the vectored interrupt unit.
// Operation
// - Sample and arbitrate pending requests every clock
// - Fastest response: detect, finish, five-cycle call
// - After return, one instruction before next call
// - Worst case nineteen clocks: return, divide, call
// - Reset vector zero; sources zero to eighteen
// - Pins and timers zero/one cleared on vectoring
// - Supply warning flag read-only; mask with enable
// - Oscillator fail flag lives in indirect space
// - Global gate bit seven overrides individual enables
// - Enable bits zero to six gate first sources
// - Timer2 request from either overflow flag
// - Pin enables pass external pin requests
// - Enable register at 0xa8, bit-addressable, all pages
// - Extended enable/priority registers serve sources 7-18
// - Request when flag, gate and enable all set
// - Higher level first, then lower order number
// - High preempts low; high never preempted
// - Flag still set after return re-enters routine
package viu_pkg;

    localparam int NUM_SOURCES = 19;
    localparam int INDEX_W = 5;

    // **********************************************************
    // Register map
    // **********************************************************
    localparam logic [7:0] INTERRUPT_ENABLE_ADDR = 8'ha8;
    localparam logic [7:0] INTERRUPT_ENABLE_RESET = 8'h00;
    localparam int GATE_BIT = 7;
    localparam int NUM_AUTO_CLEAR = 4;
    localparam int SRC_SUPPLY_WARNING = 15;
    localparam int SRC_OSC_FAIL = 17;

    // **********************************************************
    // Vectors and timing, in system clocks
    // **********************************************************
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] VECTOR_BASE = 16'h0003;
    localparam logic [15:0] VECTOR_STEP = 16'h0008;
    localparam logic [15:0] VECTOR_LAST = 16'h0093;
    localparam int DETECT_CYCLES = 1;
    localparam int FINISH_CYCLES = 1;
    localparam int CALL_CYCLES = 5;
    localparam int DIV_CYCLES = 8;
    localparam int MIN_RESPONSE = DETECT_CYCLES + FINISH_CYCLES + CALL_CYCLES;
    localparam int MAX_RESPONSE = 19;
    localparam logic [2:0] CALL_LAST = 3'(CALL_CYCLES - 1);

    typedef enum logic {VIU_IDLE, VIU_CALL} viu_state_t;

    function automatic logic [15:0] vector_of(input logic [INDEX_W-1:0] idx);
        vector_of = VECTOR_BASE + 16'(idx) * VECTOR_STEP;
    endfunction

endpackage

/* File: src/viu_arbiter.sv */
// Registered priority arbiter: picks one winner among enabled requests.
`timescale 1ns/1ps
module viu_arbiter
    import viu_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [NUM_SOURCES-1:0] request_i,
    input wire logic [NUM_SOURCES-1:0] high_level_i,
    input wire logic allow_high_i,
    input wire logic allow_low_i,
    output logic valid_o,
    output logic [INDEX_W-1:0] index_o,
    output logic high_o
);

    logic next_valid;
    logic [INDEX_W-1:0] next_index;
    logic next_high;
    logic [NUM_SOURCES-1:0] high_req;
    logic [NUM_SOURCES-1:0] low_req;

    // Lowest order number wins within one level
    function automatic logic [INDEX_W:0] pick_lowest(input logic [NUM_SOURCES-1:0] vec);
        logic [INDEX_W:0] res;
        res = '0;
        for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
            if (vec[i]) begin
                res = {1'b1, INDEX_W'(i)};
            end
        end
        return res;
    endfunction

    assign high_req = request_i & high_level_i & {NUM_SOURCES{allow_high_i}};
    assign low_req = request_i & ~high_level_i & {NUM_SOURCES{allow_low_i}};

    always_comb begin
        logic [INDEX_W:0] hi_pick;
        logic [INDEX_W:0] lo_pick;
        hi_pick = pick_lowest(high_req);
        lo_pick = pick_lowest(low_req);
        // High level is served before any low one
        if (hi_pick[INDEX_W]) begin
            next_valid = 1'b1;
            next_index = hi_pick[INDEX_W-1:0];
            next_high = 1'b1;
        end else begin
            next_valid = lo_pick[INDEX_W];
            next_index = lo_pick[INDEX_W-1:0];
            next_high = 1'b0;
        end
    end

    // One cycle to detect, resolved afresh every clock
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            valid_o <= 1'b0;
            index_o <= '0;
            high_o <= 1'b0;
        end else begin
            valid_o <= next_valid;
            index_o <= next_index;
            high_o <= next_high;
        end
    end

endmodule

/* File: src/viu_top.sv */
// Vectored interrupt unit: enable register, request gating and call sequencing.
`timescale 1ns/1ps
module viu_top
    import viu_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_bit_wr_i,
    input wire logic [7:0] sfr_bit_addr_i,
    input wire logic sfr_bit_val_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic ext_pin0_pending_i,
    input wire logic timer0_overflow_flag_i,
    input wire logic ext_pin1_pending_i,
    input wire logic timer1_overflow_flag_i,
    input wire logic uart_rx_flag_i,
    input wire logic uart_tx_flag_i,
    input wire logic timer2_high_overflow_i,
    input wire logic timer2_low_overflow_i,
    input wire logic [3:0] spi0_flags_i,
    input wire logic [7:0] periph_pending_i,
    input wire logic supply_warning_flag_i,
    input wire logic port_match_i,
    input wire logic rtc_osc_fail_flag_i,
    input wire logic [3:0] spi1_flags_i,
    input wire logic [6:0] priority_select_i,
    input wire logic [7:0] ext_enable_reg1_i,
    input wire logic [7:0] ext_priority_reg1_i,
    input wire logic [3:0] ext_enable_reg2_i,
    input wire logic [3:0] ext_priority_reg2_i,
    input wire logic insn_done_i,
    input wire logic return_from_isr_i,
    output logic irq_req_o,
    output logic vector_call_o,
    output logic [15:0] vector_addr_o,
    output logic [NUM_AUTO_CLEAR-1:0] hw_clear_o,
    output logic [1:0] in_service_o
);

    // **********************************************************
    // Enable register
    // **********************************************************
    logic [7:0] interrupt_enable;
    logic [7:0] next_interrupt_enable;
    logic [7:0] next_rdata;
    logic ie_hit;
    logic ie_bit_hit;

    // No page select reaches this decode, so every page sees it
    assign ie_hit = (sfr_addr_i == INTERRUPT_ENABLE_ADDR);
    assign ie_bit_hit = (sfr_bit_addr_i[7:3] == INTERRUPT_ENABLE_ADDR[7:3]);

    always_comb begin
        next_interrupt_enable = interrupt_enable;
        if (sfr_wr_i && ie_hit) begin
            next_interrupt_enable = sfr_wdata_i;
        end else if (sfr_bit_wr_i && ie_bit_hit) begin
            next_interrupt_enable[sfr_bit_addr_i[2:0]] = sfr_bit_val_i;
        end
        next_rdata = (sfr_rd_i && ie_hit) ? interrupt_enable : 8'h00;
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            interrupt_enable <= INTERRUPT_ENABLE_RESET;
            sfr_rdata_o <= 8'h00;
        end else begin
            interrupt_enable <= next_interrupt_enable;
            sfr_rdata_o <= next_rdata;
        end
    end

    // **********************************************************
    // Request gating
    // **********************************************************
    logic [NUM_SOURCES-1:0] pending;
    logic [NUM_SOURCES-1:0] source_enable;
    logic [NUM_SOURCES-1:0] high_level;
    logic [NUM_SOURCES-1:0] request;
    logic global_interrupt_gate;

    assign global_interrupt_gate = interrupt_enable[GATE_BIT];

    always_comb begin
        pending[0] = ext_pin0_pending_i;
        pending[1] = timer0_overflow_flag_i;
        pending[2] = ext_pin1_pending_i;
        pending[3] = timer1_overflow_flag_i;
        pending[4] = uart_rx_flag_i | uart_tx_flag_i;
        pending[5] = timer2_high_overflow_i | timer2_low_overflow_i;
        pending[6] = |spi0_flags_i;
        pending[14:7] = periph_pending_i;
        // Read-only flag: only its enable bit or the global gate can stop repeated entry
        pending[SRC_SUPPLY_WARNING] = supply_warning_flag_i;
        pending[16] = port_match_i;
        // Taken from the indirect register space, not the SFR decode
        pending[SRC_OSC_FAIL] = rtc_osc_fail_flag_i;
        pending[18] = |spi1_flags_i;
        source_enable = {ext_enable_reg2_i, ext_enable_reg1_i,
                         interrupt_enable[6:0]};
        high_level = {ext_priority_reg2_i, ext_priority_reg1_i,
                      priority_select_i};
        // Flags stay pending while masked; only the request is gated
        request = pending & source_enable
                  & {NUM_SOURCES{global_interrupt_gate}};
    end

    // **********************************************************
    // Arbitration
    // **********************************************************
    logic [1:0] in_service;
    logic [1:0] next_in_service;
    logic arb_valid;
    logic [INDEX_W-1:0] arb_index;
    logic arb_high;

    // Nothing enters over a high routine; low entries need no routine open.
    // Judged on the coming routine state, so a closing return frees a
    // waiting flag in time for the very next instruction
    viu_arbiter u_arbiter (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .request_i(request),
        .high_level_i(high_level),
        .allow_high_i(!next_in_service[1]),
        .allow_low_i(next_in_service == 2'b00),
        .valid_o(arb_valid),
        .index_o(arb_index),
        .high_o(arb_high)
    );

    assign irq_req_o = arb_valid;

    // **********************************************************
    // Call sequencing
    // **********************************************************
    viu_state_t state;
    viu_state_t next_state;
    logic [2:0] call_count;
    logic [2:0] next_call_count;
    logic [15:0] next_vector_addr;
    logic [NUM_AUTO_CLEAR-1:0] next_hw_clear;
    logic take;

    // Calls start only at an ordinary instruction boundary; the return
    // itself is no such boundary, so one more instruction always runs
    // before re-entry on a flag left set
    assign take = (state == VIU_IDLE) && arb_valid && insn_done_i
                  && !return_from_isr_i;

    always_comb begin
        next_state = state;
        next_call_count = call_count;
        next_vector_addr = vector_addr_o;
        next_hw_clear = '0;
        next_in_service = in_service;
        unique case (state)
            VIU_IDLE: begin
                if (take) begin
                    next_state = VIU_CALL;
                    next_call_count = CALL_LAST;
                    next_vector_addr = vector_of(arb_index);
                    next_in_service[arb_high] = 1'b1;
                    // Pin 0/1 and timer 0/1 flags clear here; later ones, timer2 included, are software's job
                    if (arb_index < INDEX_W'(NUM_AUTO_CLEAR)) begin
                        next_hw_clear[arb_index[1:0]] = 1'b1;
                    end
                end else if (return_from_isr_i) begin
                    // Close the innermost routine; a preempted low one resumes
                    if (in_service[1]) begin
                        next_in_service[1] = 1'b0;
                    end else begin
                        next_in_service[0] = 1'b0;
                    end
                end
            end
            VIU_CALL: begin
                if (call_count == 3'h0) begin
                    next_state = VIU_IDLE;
                end else begin
                    next_call_count = call_count - 3'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            state <= VIU_IDLE;
            call_count <= 3'h0;
            vector_addr_o <= RESET_VECTOR;
            vector_call_o <= 1'b0;
            hw_clear_o <= '0;
            in_service <= 2'b00;
            in_service_o <= 2'b00;
        end else begin
            state <= next_state;
            call_count <= next_call_count;
            vector_addr_o <= next_vector_addr;
            vector_call_o <= (next_state == VIU_CALL);
            hw_clear_o <= next_hw_clear;
            in_service <= next_in_service;
            in_service_o <= next_in_service;
        end
    end

    // **********************************************************
    // Checks
    // **********************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    gate_blocks_request_a: assert property (
        !global_interrupt_gate |=> !irq_req_o)
        else $error("request raised with global gate low");

    call_five_cycles_a: assert property (
        $rose(vector_call_o) |-> vector_call_o [*5] ##1 !vector_call_o)
        else $error("vector call not five cycles long");

    call_on_boundary_a: assert property (
        $rose(vector_call_o) |-> $past(insn_done_i) && $past(irq_req_o)
                                 && !$past(return_from_isr_i))
        else $error("vector call started off an instruction boundary");

    vector_in_table_a: assert property (
        vector_call_o |-> vector_addr_o[2:0] == 3'h3 && vector_addr_o <= VECTOR_LAST)
        else $error("vector address outside the table");

    auto_clear_low_a: assert property (
        |hw_clear_o |-> $rose(vector_call_o) && vector_addr_o <= 16'h001b
                        && $onehot(hw_clear_o))
        else $error("hardware clear outside pin or timer vectoring");

    no_clear_upper_a: assert property (
        $rose(vector_call_o) && vector_addr_o >= 16'h0023 |-> hw_clear_o == '0)
        else $error("hardware clear for software-cleared source");

    enable_write_a: assert property (
        sfr_wr_i && ie_hit |=> interrupt_enable == $past(sfr_wdata_i))
        else $error("enable register write lost");

    enable_read_a: assert property (
        sfr_rd_i && ie_hit |=> sfr_rdata_o == $past(interrupt_enable))
        else $error("enable register read wrong");

    high_not_preempted_a: assert property (
        state == VIU_IDLE && in_service[1] |=> !vector_call_o)
        else $error("high routine preempted");

    masked_no_request_a: assert property (
        request == '0 ##1 request == '0 |-> !irq_req_o)
        else $error("request raised with nothing enabled and pending");

    cover_simple_call_c: cover property (take ##1 vector_call_o [*5] ##1 !vector_call_o);
    cover_preempt_c: cover property (in_service == 2'b01 ##[1:50] in_service == 2'b11);
    cover_reentry_c: cover property (return_from_isr_i ##1 !insn_done_i ##[1:20] take);

endmodule

/* File: tb/viu_core_model.sv */
// Behavioural core model: completes instructions and returns from service routines.
`timescale 1ns/1ps
module viu_core_model
    import viu_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic slow_i,
    input wire logic ret_cmd_i,
    input wire logic vector_call_i,
    output logic insn_done_o,
    output logic return_o
);
    int count;
    logic ret_pend;

    always_ff @(posedge clock_i) begin
        insn_done_o <= 1'b0;
        return_o <= 1'b0;
        if (!reset_n_i) begin
            count <= 0;
            ret_pend <= 1'b0;
        end else begin
            // No instruction completes while the call pushes the return address
            if (vector_call_i) begin
                count <= 0;
            end else if (slow_i && count < DIV_CYCLES - 1) begin
                count <= count + 1;
            end else begin
                count <= 0;
                return_o <= ret_pend;
                insn_done_o <= !ret_pend;
                ret_pend <= 1'b0;
            end
            // Checked last so a command landing on a completion is not lost
            if (ret_cmd_i) begin
                ret_pend <= 1'b1;
            end
        end
    end
endmodule

/* File: tb/viu_top_test.sv */
// Self-checking bench for the vectored interrupt unit.
`timescale 1ns/1ps
module viu_top_test;
    import viu_pkg::*;
    typedef struct packed {
        logic [7:0] ie;
        logic [6:0] pri;
        logic [11:0] eext;
        logic [11:0] epri;
        logic [18:0] pend;
        logic [4:0] idx;
    } viu_row_t;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic bwr = 1'b0;
    logic [7:0] baddr = 8'h00;
    logic bval = 1'b0;
    logic rd = 1'b0;
    logic [18:0] pend = '0;
    logic [3:0] alt = 4'h0;
    logic [6:0] pri = 7'h00;
    logic [11:0] eext = 12'h000;
    logic [11:0] epri = 12'h000;
    logic slow = 1'b0;
    logic ret_cmd = 1'b0;
    logic insn_done;
    logic core_ret;
    logic [7:0] sfr_rdata_o;
    logic irq_req_o;
    logic vector_call_o;
    logic [15:0] vector_addr_o;
    logic [NUM_AUTO_CLEAR-1:0] hw_clear_o;
    logic [1:0] in_service_o;
    int mismatches = 0;
    int check_count = 0;
    int lat;
    viu_row_t rows [8] = '{
        '{8'h80, 7'h00, 12'h000, 12'h000, 19'h00001, 5'h1f},
        '{8'h7f, 7'h00, 12'hfff, 12'h000, 19'h7ffff, 5'h1f},
        '{8'h81, 7'h00, 12'h000, 12'h000, 19'h00001, 5'h00},
        '{8'hff, 7'h00, 12'h000, 12'h000, 19'h00028, 5'h03},
        '{8'hff, 7'h20, 12'h000, 12'h000, 19'h00028, 5'h05},
        '{8'h80, 7'h00, 12'hfff, 12'h000, 19'h00180, 5'h07},
        '{8'h80, 7'h00, 12'hfff, 12'h002, 19'h00180, 5'h08},
        '{8'hff, 7'h00, 12'heff, 12'h000, 19'h08000, 5'h1f}
    };

    viu_top u_dut (.clock_i(clock), .reset_n_i(reset_n), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_wdata_i(wdata), .sfr_bit_wr_i(bwr), .sfr_bit_addr_i(baddr), .sfr_bit_val_i(bval),
        .sfr_rd_i(rd), .sfr_rdata_o(sfr_rdata_o), .ext_pin0_pending_i(pend[0]),
        .timer0_overflow_flag_i(pend[1]), .ext_pin1_pending_i(pend[2]),
        .timer1_overflow_flag_i(pend[3]), .uart_rx_flag_i(pend[4]), .uart_tx_flag_i(alt[0]),
        .timer2_high_overflow_i(pend[5]), .timer2_low_overflow_i(alt[1]),
        .spi0_flags_i({alt[2], 2'b00, pend[6]}), .periph_pending_i(pend[14:7]),
        .supply_warning_flag_i(pend[15]), .port_match_i(pend[16]),
        .rtc_osc_fail_flag_i(pend[17]), .spi1_flags_i({alt[3], 2'b00, pend[18]}),
        .priority_select_i(pri), .ext_enable_reg1_i(eext[7:0]),
        .ext_priority_reg1_i(epri[7:0]), .ext_enable_reg2_i(eext[11:8]),
        .ext_priority_reg2_i(epri[11:8]), .insn_done_i(insn_done),
        .return_from_isr_i(core_ret), .irq_req_o(irq_req_o), .vector_call_o(vector_call_o),
        .vector_addr_o(vector_addr_o), .hw_clear_o(hw_clear_o), .in_service_o(in_service_o));

    viu_core_model u_core (.clock_i(clock), .reset_n_i(reset_n), .slow_i(slow),
        .ret_cmd_i(ret_cmd), .vector_call_i(vector_call_o), .insn_done_o(insn_done),
        .return_o(core_ret));

    initial begin
        forever #5 clock = ~clock;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic step(inout int n);
        @(negedge clock);
        n++;
        if (n > 40) begin
            mismatches++;
            give_verdict();
        end
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clock);
        wr = 1'b0;
        @(negedge clock);
    endtask

    task automatic sfr_bit(input logic [7:0] a, input logic v);
        baddr = a;
        bval = v;
        bwr = 1'b1;
        @(negedge clock);
        bwr = 1'b0;
        @(negedge clock);
    endtask

    // Checks the answer and that it stands a single cycle
    task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        @(negedge clock);
        rd = 1'b0;
        check({8'h00, sfr_rdata_o}, {8'h00, exp});
        @(negedge clock);
        check({8'h00, sfr_rdata_o}, 16'h0000);
    endtask

    task automatic serve(input int idx, input int exp_lat);
        int n;
        n = 0;
        while (vector_call_o !== 1'b1) step(n);
        check(16'(n), 16'(exp_lat));
        check(vector_addr_o, 16'h0003 + 16'(idx) * 16'h0008);
        check(16'(hw_clear_o), (idx < 4) ? 16'(1 << idx) : 16'h0000);
        n = 0;
        while (vector_call_o === 1'b1) step(n);
        check(16'(n), 16'h0005);
        // The routine clears its own flags, then one edge passes before new ones
        pend = '0;
        alt = 4'h0;
        @(negedge clock);
    endtask

    task automatic ret_isr();
        int n;
        ret_cmd = 1'b1;
        @(negedge clock);
        ret_cmd = 1'b0;
        n = 0;
        while (core_ret !== 1'b1) step(n);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(negedge clock);
        check(vector_addr_o, 16'h0000);
        reset_n = 1'b1;
        // The first edge out of reset carries no request
        @(negedge clock);
        sfr_read(8'ha8, 8'h00);
        sfr_write(8'ha8, 8'h5a);
        sfr_write(8'ha9, 8'hff);
        sfr_read(8'ha8, 8'h5a);
        sfr_read(8'ha9, 8'h00);
        sfr_bit(8'haf, 1'b1);
        sfr_bit(8'ha9, 1'b0);
        sfr_bit(8'hb0, 1'b1);
        sfr_read(8'ha8, 8'hd8);
        addr = 8'ha8;
        wdata = 8'h00;
        baddr = 8'ha8;
        bval = 1'b1;
        wr = 1'b1;
        bwr = 1'b1;
        @(negedge clock);
        wr = 1'b0;
        bwr = 1'b0;
        sfr_read(8'ha8, 8'h00);
        for (int r = 0; r < 8; r++) begin
            pri = rows[r].pri;
            eext = rows[r].eext;
            epri = rows[r].epri;
            sfr_write(8'ha8, rows[r].ie);
            pend = rows[r].pend;
            if (rows[r].idx === 5'h1f) begin
                repeat (4) @(negedge clock);
                check(16'(irq_req_o), 16'h0000);
                check(16'(vector_call_o), 16'h0000);
                pend = '0;
            end else begin
                @(negedge clock);
                check(16'(irq_req_o), 16'h0001);
                serve(int'(rows[r].idx), 1);
                ret_isr();
                repeat (2) @(negedge clock);
            end
        end
        pri = 7'h00;
        epri = 12'h000;
        eext = 12'hfff;
        sfr_write(8'ha8, 8'hff);
        for (int n = 0; n < NUM_SOURCES; n++) begin
            pend = 19'(1) << n;
            serve(n, 2);
            ret_isr();
            repeat (2) @(negedge clock);
        end
        for (int k = 0; k < 4; k++) begin
            alt = 4'(1 << k);
            serve((k < 3) ? k + 4 : 18, 2);
            ret_isr();
            repeat (2) @(negedge clock);
        end
        pri = 7'h02;
        pend = 19'h00001;
        serve(0, 2);
        pend = 19'h00002;
        serve(1, 2);
        check(16'(in_service_o), 16'h0003);
        pend = 19'h00001;
        repeat (8) @(negedge clock);
        check(16'(vector_call_o), 16'h0000);
        ret_isr();
        repeat (6) @(negedge clock);
        check(16'(in_service_o), 16'h0001);
        check(16'(vector_call_o), 16'h0000);
        ret_isr();
        serve(0, 2);
        pend = 19'h00001;
        slow = 1'b1;
        ret_isr();
        serve(0, DIV_CYCLES + 1);
        slow = 1'b0;
        ret_isr();
        pend = 19'h00001;
        repeat (3) @(negedge clock);
        reset_n = 1'b0;
        repeat (2) @(negedge clock);
        check(16'(vector_call_o), 16'h0000);
        check(vector_addr_o, 16'h0000);
        check(16'(in_service_o), 16'h0000);
        reset_n = 1'b1;
        pend = '0;
        @(negedge clock);
        sfr_read(8'ha8, 8'h00);
        give_verdict();
    end
endmodule
